/* rtl/oss_pkg.sv */
// Constants, register layout and oversampling table for the sleep/oversampling control.
// Assumes a single 250 MHz sampling-domain clock and a simple byte-wide register port.
// Behaviour
// - Bit 2 of sleep mode control enables automatic sleep and wake transitions.
// - With auto-sleep on, each sleep/wake change resets event counters and, with FIFO gate clear, flushes FIFO.
// - Latched event status survives sleep/wake changes; only counters are reset.
// - Bits 1..0 of sleep mode control pick the wake oversampling mode.
// - Mode codes: 00 normal, 01 low-noise low-power, 10 high-res, 11 low-power.
// - Normal and high-resolution ratios follow their per-rate tables.
// - Low-noise low-power and low-power ratios follow their per-rate tables.
// - Interrupt control: gate, five wake bits, polarity, drive; all RW, reset zero.
// - Bits 4..3 of sleep mode control pick the sleep oversampling mode.
// - FIFO gating blocks new samples after a transition until emptied; flags gate error.
// - Each wake bit keeps its detection function running during sleep.
// - Polarity 0 active low, 1 active high; drive 0 push-pull, 1 open-drain.
package oss_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_SLEEP_MODE_CONTROL = 8'h2A;
  localparam logic [7:0] ADDR_INTERRUPT_CONTROL  = 8'h2C;
  localparam logic [7:0] RST_SLEEP_MODE_CONTROL  = 8'h00;
  localparam logic [7:0] RST_INTERRUPT_CONTROL   = 8'h00;
  localparam logic [7:0] SMC_WRITE_MASK          = 8'h1F;

  // ==========================================================================
  // Field layouts
  typedef struct packed {
    logic [2:0] reserved;
    logic [1:0] sleep_osr_mode;
    logic       auto_sleep_en;
    logic [1:0] wake_osr_mode;
  } oss_smc_s;

  typedef struct packed {
    logic       fifo_gate;
    logic       wake_transient;
    logic       wake_orient;
    logic       wake_tap;
    logic       wake_ffmt;
    logic       wake_vecm;
    logic       irq_polarity;
    logic       irq_drive_style;
  } oss_ictrl_s;

  typedef enum logic [1:0] {
    OSR_NORMAL   = 2'b00,
    OSR_LNLP     = 2'b01,
    OSR_HIRES    = 2'b10,
    OSR_LOWPOWER = 2'b11
  } oss_mode_e;

  localparam int RATE_W  = 3;
  localparam int RATIO_W = 11;
  localparam int NUM_FUNC = 5;

  // ==========================================================================
  // Ratio table, index [mode][rate]; rate 0 = 1.5625 Hz .. rate 7 = 800 Hz
  localparam logic [3:0][7:0][10:0] OSR_TABLE = {
    // Low power
    {11'h002, 11'h002, 11'h002, 11'h002, 11'h002, 11'h002, 11'h004, 11'h010},
    // High resolution
    {11'h002, 11'h004, 11'h008, 11'h010, 11'h020, 11'h080, 11'h100, 11'h400},
    // Low noise, low power
    {11'h002, 11'h004, 11'h004, 11'h004, 11'h004, 11'h004, 11'h008, 11'h020},
    // Normal
    {11'h002, 11'h004, 11'h004, 11'h004, 11'h004, 11'h010, 11'h020, 11'h080}
  };

endpackage

/* rtl/oss_sleep_ctrl.sv */
// Sleep/wake oversampling control with interrupt control register and FIFO gating.
// Assumes inputs are synchronous to ref_clk_i; rate selects come from elsewhere.
`timescale 1ns/1ps
module oss_sleep_ctrl (
  // Clock and reset
  input  wire logic                            ref_clk_i,
  input  wire logic                            sys_rst_i,
  // Register port
  input  wire logic                            reg_wr_i,
  input  wire logic [7:0]                      reg_addr_i,
  input  wire logic [7:0]                      reg_wdata_i,
  output logic      [7:0]                      reg_rdata_o,
  // System state and sample timing
  input  wire logic                            sys_sleep_i,
  input  wire logic                            sample_tick_i,
  input  wire logic [oss_pkg::RATE_W-1:0]      wake_output_rate_i,
  input  wire logic [oss_pkg::RATE_W-1:0]      sleep_output_rate_i,
  input  wire logic                            fifo_empty_i,
  // Derived controls
  output logic                                 fifo_flush_o,
  output logic                                 counter_reset_o,
  output logic                                 fifo_accept_o,
  output logic                                 gate_err_o,
  output logic [1:0]                           power_mode_o,
  output logic [oss_pkg::RATIO_W-1:0]          osr_ratio_o,
  output logic [oss_pkg::NUM_FUNC-1:0]         func_run_o,
  // Interrupt pins
  input  wire logic                            irq_one_req_i,
  input  wire logic                            irq_two_req_i,
  output logic                                 irq_line_one_o,
  output logic                                 irq_line_one_oe_o,
  output logic                                 irq_line_two_o,
  output logic                                 irq_line_two_oe_o
);

  // ==========================================================================
  // Registers
  oss_pkg::oss_smc_s   smc_q;
  oss_pkg::oss_ictrl_s ictrl_q;
  logic                sleep_prev_q;
  logic                gate_block_q;

  wire wr_smc   = reg_wr_i && (reg_addr_i == oss_pkg::ADDR_SLEEP_MODE_CONTROL);
  wire wr_ictrl = reg_wr_i && (reg_addr_i == oss_pkg::ADDR_INTERRUPT_CONTROL);
  wire oss_pkg::oss_smc_s wdata_smc = reg_wdata_i;
  wire [7:0] rd_mux = (reg_addr_i == oss_pkg::ADDR_SLEEP_MODE_CONTROL) ? smc_q :
                      (reg_addr_i == oss_pkg::ADDR_INTERRUPT_CONTROL) ? ictrl_q : 8'h00;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      smc_q   <= oss_pkg::RST_SLEEP_MODE_CONTROL;
      ictrl_q <= oss_pkg::RST_INTERRUPT_CONTROL;
    end else begin
      if (wr_smc) begin
        smc_q <= reg_wdata_i & oss_pkg::SMC_WRITE_MASK;
      end
      if (wr_ictrl) begin
        ictrl_q <= reg_wdata_i;
      end
    end
  end

  // ==========================================================================
  // Sleep/wake transitions
  wire transition = smc_q.auto_sleep_en && (sys_sleep_i != sleep_prev_q);
  wire do_flush   = transition && !ictrl_q.fifo_gate;
  wire gate_set   = transition && ictrl_q.fifo_gate;
  wire gate_next  = gate_set || (gate_block_q && !fifo_empty_i);            // set wins over clear
  wire err_next   = gate_next && !fifo_empty_i && (gate_err_o || sample_tick_i);

  // Functions run while awake, or in sleep if their wake bit is set
  wire [oss_pkg::NUM_FUNC-1:0] wake_bits = {ictrl_q.wake_transient, ictrl_q.wake_orient,
                                            ictrl_q.wake_tap, ictrl_q.wake_ffmt, ictrl_q.wake_vecm};
  wire [oss_pkg::NUM_FUNC-1:0] run_next  = sys_sleep_i ? wake_bits : {oss_pkg::NUM_FUNC{1'b1}};

  // ==========================================================================
  // Oversampling selection
  wire [1:0]                       mode_sel = sys_sleep_i ? smc_q.sleep_osr_mode : smc_q.wake_osr_mode;
  wire [oss_pkg::RATE_W-1:0]       rate_sel = sys_sleep_i ? sleep_output_rate_i : wake_output_rate_i;
  wire [oss_pkg::RATIO_W-1:0]      ratio_sel = oss_pkg::OSR_TABLE[mode_sel][rate_sel];

  // ==========================================================================
  // Interrupt pin drive
  // One pin driver per interrupt line; index 0 is line one
  wire [1:0] irq_req = {irq_two_req_i, irq_one_req_i};
  wire [1:0] irq_lvl;
  wire [1:0] irq_oe;
  wire [1:0] irq_out;
  for (genvar j = 0; j < 2; j++) begin : g_irq_pin
    assign irq_lvl[j] = irq_req[j] ~^ ictrl_q.irq_polarity;
    assign irq_oe[j]  = ictrl_q.irq_drive_style ? !irq_lvl[j] : 1'b1;
    assign irq_out[j] = ictrl_q.irq_drive_style ? 1'b0 : irq_lvl[j];
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sleep_prev_q      <= 1'b0;
      gate_block_q      <= 1'b0;
      fifo_flush_o      <= 1'b0;
      counter_reset_o   <= 1'b0;
      fifo_accept_o     <= 1'b1;
      gate_err_o        <= 1'b0;
      power_mode_o      <= oss_pkg::OSR_NORMAL;
      osr_ratio_o       <= oss_pkg::OSR_TABLE[0][0];
      func_run_o        <= {oss_pkg::NUM_FUNC{1'b1}};
      irq_line_one_o    <= 1'b1;
      irq_line_one_oe_o <= 1'b1;
      irq_line_two_o    <= 1'b1;
      irq_line_two_oe_o <= 1'b1;
    end else begin
      sleep_prev_q      <= sys_sleep_i;
      gate_block_q      <= gate_next;
      fifo_flush_o      <= do_flush;
      counter_reset_o   <= transition;      // status is left alone
      fifo_accept_o     <= !gate_next;
      gate_err_o        <= err_next;
      func_run_o        <= run_next;
      irq_line_one_o    <= irq_out[0];
      irq_line_one_oe_o <= irq_oe[0];
      irq_line_two_o    <= irq_out[1];
      irq_line_two_oe_o <= irq_oe[1];
      if (sample_tick_i) begin
        power_mode_o <= mode_sel;
        osr_ratio_o  <= ratio_sel;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= rd_mux;
    end
  end

  // ==========================================================================
  // Assertions
  transition_counter_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (smc_q.auto_sleep_en && $changed(sys_sleep_i)) |=> counter_reset_o)
    else $error("transition did not reset counters");

  no_auto_quiet_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!smc_q.auto_sleep_en && $stable(sys_sleep_i)) |=> !counter_reset_o && !fifo_flush_o)
    else $error("counter reset without transition");

  gate_blocks_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (transition && ictrl_q.fifo_gate) |=> !fifo_accept_o && !fifo_flush_o)
    else $error("gated transition did not block FIFO");

  gate_release_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (fifo_empty_i && !transition) |=> fifo_accept_o && !gate_err_o)
    else $error("empty FIFO did not release gate");

  gate_error_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!fifo_accept_o && sample_tick_i && !fifo_empty_i && !transition) |=> gate_err_o)
    else $error("gate error not flagged");

  ratio_hold_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !sample_tick_i |=> $stable(osr_ratio_o) && $stable(power_mode_o))
    else $error("ratio changed mid sample");

  hires_low_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (sample_tick_i && !sys_sleep_i && smc_q.wake_osr_mode == 2'b10 && wake_output_rate_i == 3'h0)
    |=> osr_ratio_o == 11'h400)
    else $error("high resolution ratio wrong");

  lowpower_low_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (sample_tick_i && sys_sleep_i && smc_q.sleep_osr_mode == 2'b11 && sleep_output_rate_i == 3'h1)
    |=> osr_ratio_o == 11'h004)
    else $error("low power ratio wrong");

  sleep_run_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    sys_sleep_i |=> func_run_o == $past(wake_bits))
    else $error("sleep function enables wrong");

  push_pull_one_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!ictrl_q.irq_drive_style) |=> irq_line_one_oe_o && (irq_line_one_o == $past(irq_lvl[0])))
    else $error("push-pull level wrong");

  open_drain_two_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    ictrl_q.irq_drive_style |=> !irq_line_two_o && (irq_line_two_oe_o == !$past(irq_lvl[1])))
    else $error("open-drain drive wrong");

  push_pull_two_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!ictrl_q.irq_drive_style) |=> irq_line_two_oe_o && (irq_line_two_o == $past(irq_lvl[1])))
    else $error("push-pull level wrong on line two");

  open_drain_one_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    ictrl_q.irq_drive_style |=> !irq_line_one_o && (irq_line_one_oe_o == !$past(irq_lvl[0])))
    else $error("open-drain drive wrong on line one");

  ictrl_rw_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    wr_ictrl |=> ictrl_q == $past(reg_wdata_i))
    else $error("interrupt control write lost");

  rdata_map_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (reg_addr_i == oss_pkg::ADDR_INTERRUPT_CONTROL) |=> reg_rdata_o == $past(ictrl_q))
    else $error("interrupt control readback wrong");

  smc_write_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    wr_smc |=> (smc_q.auto_sleep_en == $past(wdata_smc.auto_sleep_en))
      && (smc_q.wake_osr_mode == $past(wdata_smc.wake_osr_mode))
      && (smc_q.sleep_osr_mode == $past(wdata_smc.sleep_osr_mode)) && (smc_q.reserved == 3'h0))
    else $error("sleep mode control write lost");

  flush_pulse_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (transition && !ictrl_q.fifo_gate) |=> fifo_flush_o)
    else $error("ungated transition did not flush");

  flush_with_reset_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    fifo_flush_o |-> counter_reset_o)
    else $error("flush without counter reset");

  status_keep_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (transition && gate_err_o && !fifo_empty_i) |=> gate_err_o)
    else $error("status lost across transition");

  awake_run_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !sys_sleep_i |=> func_run_o == {oss_pkg::NUM_FUNC{1'b1}})
    else $error("function stopped while awake");

  lnlp_mid_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (sample_tick_i && !sys_sleep_i && smc_q.wake_osr_mode == 2'b01 && wake_output_rate_i == 3'h1)
    |=> osr_ratio_o == 11'h008)
    else $error("low-noise low-power ratio wrong");

endmodule

/* test/oss_fifo_host_model.sv */
// Host-side FIFO occupancy model for the sleep/oversampling control bench.
// Assumes flush and accept come from the control block; drain_i is the host emptying the FIFO.
`timescale 1ns/1ps
module oss_fifo_host_model (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  // Sample flow
  input  wire logic sample_tick_i,
  input  wire logic fifo_accept_i,
  input  wire logic fifo_flush_i,
  input  wire logic drain_i,
  // Status
  output logic      fifo_empty_o
);
  logic [5:0] fill_q;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) fill_q <= 6'h00;
    else if (fifo_flush_i || drain_i) fill_q <= 6'h00;
    else if (sample_tick_i && fifo_accept_i && fill_q != 6'h20) fill_q <= fill_q + 6'h01;
  end
  assign fifo_empty_o = (fill_q == 6'h00);
endmodule

/* test/testbench.sv */
// Self-checking bench for the sleep/oversampling control block.
// Assumes the block's registered one-cycle latencies; interrupt wires have a pull-up.
`timescale 1ns/1ps
module testbench;
  localparam int OSR_T [4][8] = '{'{128, 32, 16, 4, 4, 4, 4, 2}, '{32, 8, 4, 4, 4, 4, 4, 2},
                                  '{1024, 256, 128, 32, 16, 8, 4, 2}, '{16, 4, 2, 2, 2, 2, 2, 2}};
  logic        ref_clk_i = 1'b0, sys_rst_i = 1'b1, wr = 1'b0, slp = 1'b0, tick = 1'b0;
  logic        drain = 1'b0, rq1 = 1'b0, rq2 = 1'b0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, d, smc;
  logic [2:0]  wrate = 3'h0, srate = 3'h0;
  logic [10:0] prev = 11'h080;
  logic [31:0] seed = 32'h00006DD7;
  int          n_errors = 0, checks = 0, n_cr = 0, n_fl = 0, base, fl;
  wire logic [7:0]  rdata;
  wire logic [10:0] osr;
  wire logic [4:0]  frun;
  wire logic [1:0]  pmode;
  wire logic        flush, cr, acc, gerr, l1, o1, l2, o2, empty;
  wire logic        lvl1 = o1 ? l1 : 1'b1;
  wire logic        lvl2 = o2 ? l2 : 1'b1;

  // ==========================================================================
  // Design, host model, clock
  oss_sleep_ctrl dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(wr), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .sys_sleep_i(slp), .sample_tick_i(tick),
    .wake_output_rate_i(wrate), .sleep_output_rate_i(srate), .fifo_empty_i(empty), .fifo_flush_o(flush),
    .counter_reset_o(cr), .fifo_accept_o(acc), .gate_err_o(gerr), .power_mode_o(pmode), .osr_ratio_o(osr),
    .func_run_o(frun), .irq_one_req_i(rq1), .irq_two_req_i(rq2), .irq_line_one_o(l1),
    .irq_line_one_oe_o(o1), .irq_line_two_o(l2), .irq_line_two_oe_o(o2));
  oss_fifo_host_model host (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .sample_tick_i(tick),
    .fifo_accept_i(acc), .fifo_flush_i(flush), .drain_i(drain), .fifo_empty_o(empty));
  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  always @(negedge ref_clk_i) begin
    if (cr === 1'b1) n_cr++;
    if (flush === 1'b1) n_fl++;
  end

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    addr = a;
    wdata = v;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask
  function automatic logic [10:0] exp_osr(input logic [1:0] m, input logic [2:0] r);
    return 11'(OSR_T[m][r]);
  endfunction
  function automatic logic exp_pin(input logic pol, input logic req);
    return pol ? req : !req;
  endfunction
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    cyc(2);
    chk({3'h0, rdata}, {3'h0, e}, "register readback");
  endtask
  task automatic summarize();
    if (n_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    summarize();
  end

  // ==========================================================================
  // Scenarios
  initial begin
    cyc(10);
    sys_rst_i = 1'b0;
    rd_chk(8'h2C, 8'h00);
    rd_chk(8'h2A, 8'h00);
    wr_reg(8'h55, 8'hFF);
    rd_chk(8'h55, 8'h00);
    seed = xs(seed);
    wr_reg(8'h2C, seed[7:0]);
    rd_chk(8'h2C, seed[7:0]);
    wr_reg(8'h2A, 8'hFF);
    rd_chk(8'h2A, 8'h1F);
    wr_reg(8'h2C, 8'h00);
    base = n_cr;
    for (int i = 0; i < 64; i++) begin
      seed = xs(seed);
      d = seed[7:0];
      smc = i[5] ? {3'h0, i[1:0], 1'b0, d[1:0]} : {3'h0, d[4:3], 1'b0, i[1:0]};
      slp = i[5];
      wrate = i[5] ? d[7:5] : i[4:2];
      srate = i[5] ? i[4:2] : d[7:5];
      wr_reg(8'h2A, smc);
      chk(osr, prev, "ratio changed without tick");
      tick = 1'b1;
      cyc(1);
      tick = 1'b0;
      cyc(1);
      prev = exp_osr(i[1:0], i[4:2]);
      chk(osr, prev, "oversampling ratio");
      chk({9'h000, pmode}, {9'h000, i[1:0]}, "power mode");
    end
    chk(11'(n_cr - base), 11'h000, "counter reset with auto-sleep off");
    for (int g = 0; g < 2; g++) begin
      wr_reg(8'h2C, {g[0], 7'h00});
      wr_reg(8'h2A, 8'h04);
      tick = 1'b1;
      cyc(1);
      tick = 1'b0;
      base = n_cr;
      fl = n_fl;
      slp = ~slp;
      cyc(4);
      chk(11'(n_cr - base), 11'h001, "counter reset pulse");
      chk(11'(n_fl - fl), g[0] ? 11'h000 : 11'h001, "flush pulse");
      chk(acc, !g[0], "accept after transition");
    end
    tick = 1'b1;
    cyc(1);
    tick = 1'b0;
    cyc(2);
    chk({gerr, acc}, 11'h002, "gate error while blocked");
    slp = ~slp;
    cyc(2);
    chk({gerr, acc}, 11'h002, "gate status across transition");
    drain = 1'b1;
    cyc(1);
    drain = 1'b0;
    cyc(3);
    chk({gerr, acc}, 11'h001, "gate released after empty");
    seed = xs(seed);
    d = {1'b0, seed[6:0]};
    wr_reg(8'h2C, d);
    cyc(1);
    chk(frun, slp ? d[6:2] : 5'h1F, "functions running");
    slp = ~slp;
    cyc(2);
    chk(frun, slp ? d[6:2] : 5'h1F, "functions after mode change");
    for (int k = 0; k < 16; k++) begin
      seed = xs(seed);
      rq1 = k[2];
      rq2 = seed[0] ^ k[3];
      wr_reg(8'h2C, {6'h00, k[0], k[1]});
      cyc(1);
      chk(lvl1, exp_pin(k[0], rq1), "line one level");
      chk(lvl2, exp_pin(k[0], rq2), "line two level");
      chk({o1 | k[1], l1 & k[1]}, 11'h002, "drive style");
      chk({o2 | k[1], l2 & k[1]}, 11'h002, "drive style line two");
    end
    summarize();
  end
endmodule
